/* hw/lcp_pkg.sv */
`default_nettype none
package lcp_pkg;

    // ------------------------------------------------------------
    // Register map (serial bus register addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CH9_CONTROL = 8'h0E;
    localparam logic [7:0] ADDR_CH1_DUTY    = 8'h16;
    localparam logic [7:0] ADDR_CH2_DUTY    = 8'h17;
    localparam logic [7:0] ADDR_NOINC_FIRST = 8'h16;
    localparam logic [7:0] ADDR_NOINC_LAST  = 8'h1E;
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;

    // Reset values
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [7:0] RESET_DUTY    = 8'h00;

    // ------------------------------------------------------------
    // Channel control layout: fader map 7:6, curve 5, slope 4:0
    // ------------------------------------------------------------
    localparam logic [1:0] FADER_NONE   = 2'h0;
    localparam logic       CURVE_LINEAR = 1'b0;
    localparam logic       CURVE_LOG    = 1'b1;
    localparam logic [4:0] SLOPE_OFF    = 5'h00;

    typedef struct packed {
        logic [1:0] fader_select;
        logic       curve_select;
        logic [4:0] thermal_slope;
    } lcp_ctrl_t;

    typedef logic [7:0] lcp_duty_t;

    // ------------------------------------------------------------
    // Thermal and PWM constants
    // ------------------------------------------------------------
    localparam logic signed [8:0] REF_TEMP_C      = 9'sd25;
    localparam int                THERMAL_SHIFT   = 10;
    localparam lcp_duty_t         DUTY_FULL       = 8'hFF;
    localparam lcp_duty_t         PWM_TOP         = 8'hFE;
    localparam int                NUM_CH          = 3;
    localparam int                CH_IDX_9        = 2;

    // Serial bus slave
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A; // Arbitrary value
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

    typedef enum logic [3:0] {
        SB_IDLE, SB_DEVADDR, SB_ACK_DEV, SB_REGADDR, SB_ACK_REG,
        SB_WDATA, SB_ACK_W, SB_RDATA, SB_ACK_R
    } lcp_sb_state_t;

endpackage : lcp_pkg
`default_nettype wire

/* hw/lcp_chan_pwm.sv */
`default_nettype none
module lcp_chan_pwm (
    input  wire logic              mclk_in,
    input  wire logic              reset_n_in,
    input  wire lcp_pkg::lcp_ctrl_t ctrl_in,
    input  wire lcp_pkg::lcp_duty_t direct_duty_in,
    input  wire lcp_pkg::lcp_duty_t engine_duty_in,
    input  wire logic              engine_active_in,
    input  wire logic [23:0]       fader_levels_in,
    input  wire logic signed [7:0] temperature_in,
    output logic                   pwm_out
);
    import lcp_pkg::*;

    lcp_duty_t          base;
    lcp_duty_t          fader_level;
    lcp_duty_t          faded;
    lcp_duty_t          curved;
    logic [15:0]        fade_prod;
    logic [15:0]        curve_prod;
    logic               slope_neg;
    logic [3:0]         slope_mag;
    logic signed [5:0]  slope_val;
    logic signed [8:0]  delta;
    logic signed [13:0] slope_delta;
    logic signed [22:0] corr_full;
    logic signed [12:0] corr;
    logic signed [12:0] sum;
    lcp_duty_t          eff_duty;
    lcp_duty_t          cnt;

    // ------------------------------------------------------------
    // Effective duty
    // ------------------------------------------------------------
    assign base = engine_active_in ? engine_duty_in : direct_duty_in;

    // Product plus base keeps full scale times full scale at full scale
    assign fader_level = fader_levels_in[8*(ctrl_in.fader_select - 2'h1) +: 8];
    assign fade_prod   = 16'(base) * 16'(fader_level) + 16'(base);
    assign faded = (ctrl_in.fader_select == FADER_NONE) ? base : fade_prod[15:8];

    // Square law stands in for the logarithmic curve: cheap and monotonic
    assign curve_prod = 16'(faded) * 16'(faded) + 16'(faded);
    assign curved = (ctrl_in.curve_select == CURVE_LOG) ? curve_prod[15:8] : faded;

    // Zero deviation or zero slope gives zero correction
    assign delta       = {temperature_in[7], temperature_in} - REF_TEMP_C;
    // Sign and magnitude, not two's complement: the top code is the steepest negative slope
    assign {slope_neg, slope_mag} = ctrl_in.thermal_slope;
    assign slope_val   = slope_neg ? -$signed({2'b00, slope_mag})
                                   : $signed({2'b00, slope_mag});
    assign slope_delta = 14'(slope_val) * 14'(delta);
    assign corr_full   = $signed({1'b0, curved}) * slope_delta;
    assign corr        = corr_full[22:THERMAL_SHIFT];
    assign sum         = $signed({5'h00, curved}) + corr;

    always_comb begin
        if (sum < 13'sd0) begin
            eff_duty = 8'h00;
        end else if (sum > $signed({5'h00, DUTY_FULL})) begin
            eff_duty = DUTY_FULL;
        end else begin
            eff_duty = sum[7:0];
        end
    end

    // ------------------------------------------------------------
    // PWM: period of 255 counts, so each code adds 1/255
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt <= 8'h00;
        end else if (cnt == PWM_TOP) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    // Full code is above every count, so the output never drops
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (cnt < eff_duty);
        end
    end

endmodule : lcp_chan_pwm
`default_nettype wire

/* hw/lcp_led_ctrl.sv */
`default_nettype none
// How it works
// - Control bits 7:6 route channel 9 to no fader or fader 1-3; reset 00.
// - Control bit 5 picks linear or logarithmic curve, for engine and direct duty.
// - Control bits 4:0 set thermal slope in 0.1 steps, -1.5 to +1.5; reset 0.
// - Slope code is signed; 00000 turns thermal correction off.
// - Correction is zero at 25 degrees and grows with deviation from it.
// - Duty registers drive outputs only while no program engine drives them.
// - After reset direct duty control is in force.
// - No address auto-increment for accesses to addresses 0x16 to 0x1E.
// - Eight-bit duty code is linear, 1/255 of full duty per step.
// - Code FF holds output fully on; duty registers reset to zero.
// - Channel 2 duty register at 0x17, channel 1 at 0x16, same encoding.
// - A fader dims all outputs mapped to it, scaling each ratiometrically.
module lcp_led_ctrl #(
    parameter logic [6:0] DEV_ADDR = lcp_pkg::DEV_ADDR_DEFAULT
) (
    input  wire logic                             mclk_in,
    input  wire logic                             reset_n_in,
    input  wire logic                             scl_in,
    input  wire logic                             sda_in,
    output logic                                  sda_out,
    output logic                                  sda_oe_out,
    input  wire lcp_pkg::lcp_ctrl_t               ctrl_ch1_in,
    input  wire lcp_pkg::lcp_ctrl_t               ctrl_ch2_in,
    input  wire lcp_pkg::lcp_duty_t               duty_ch9_in,
    input  wire lcp_pkg::lcp_duty_t [2:0]         engine_duty_in,
    input  wire logic [2:0]                       engine_active_in,
    input  wire logic [23:0]                      fader_levels_in,
    input  wire logic signed [7:0]                temperature_in,
    output logic [2:0]                            pwm_out
);
    import lcp_pkg::*;

    lcp_ctrl_t     channel9_control;
    lcp_duty_t     channel1_duty;
    lcp_duty_t     channel2_duty;

    logic [1:0]    scl_sync;
    logic [1:0]    sda_sync;
    logic          scl_q;
    logic          sda_q;
    logic          scl_rise;
    logic          scl_fall;
    logic          bus_start;
    logic          bus_stop;

    lcp_sb_state_t state;
    logic [3:0]    bitcnt;
    logic [7:0]    shreg;
    logic [7:0]    txreg;
    logic [7:0]    ptr;
    logic          rw_read;
    logic          host_nack;
    logic          byte_done;
    logic          write_strobe;
    logic          ptr_advance;
    logic [7:0]    next_ptr;
    logic [7:0]    read_addr;
    logic [7:0]    read_data;

    lcp_ctrl_t [2:0] ctrl_arr;
    lcp_duty_t [2:0] duty_arr;

    // ------------------------------------------------------------
    // Pin synchronisers and bus conditions
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_sync[1];
            sda_q <= sda_sync[1];
        end
    end

    assign scl_rise  = scl_sync[1] & ~scl_q;
    assign scl_fall  = ~scl_sync[1] & scl_q;
    assign bus_start = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
    assign bus_stop  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
    assign byte_done = scl_fall & (bitcnt == BITS_PER_BYTE);

    // ------------------------------------------------------------
    // Register pointer and read mux
    // ------------------------------------------------------------
    always_comb begin
        if (ptr >= ADDR_NOINC_FIRST && ptr <= ADDR_NOINC_LAST) begin
            next_ptr = ptr;
        end else begin
            next_ptr = ptr + 8'h01;
        end
    end

    // The next read byte is fetched while the pointer steps, so look one ahead
    assign read_addr = (state == SB_ACK_R) ? next_ptr : ptr;

    always_comb begin
        unique case (read_addr)
            ADDR_CH9_CONTROL: read_data = channel9_control;
            ADDR_CH1_DUTY:    read_data = channel1_duty;
            ADDR_CH2_DUTY:    read_data = channel2_duty;
            default:          read_data = READ_UNMAPPED;
        endcase
    end

    assign write_strobe = byte_done & (state == SB_WDATA);
    assign ptr_advance  = scl_fall & ((state == SB_ACK_W)
                        | (state == SB_ACK_R & ~host_nack));

    // ------------------------------------------------------------
    // Serial bus slave state machine
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= SB_IDLE;
        end else if (bus_stop) begin
            state <= SB_IDLE;
        end else if (bus_start) begin
            state <= SB_DEVADDR;
        end else if (scl_fall) begin
            unique case (state)
                SB_IDLE:    state <= SB_IDLE;
                SB_DEVADDR: if (byte_done) begin
                    state <= (shreg[7:1] == DEV_ADDR) ? SB_ACK_DEV : SB_IDLE;
                end
                SB_ACK_DEV: state <= rw_read ? SB_RDATA : SB_REGADDR;
                SB_REGADDR: if (byte_done) begin
                    state <= SB_ACK_REG;
                end
                SB_ACK_REG: state <= SB_WDATA;
                SB_WDATA:   if (byte_done) begin
                    state <= SB_ACK_W;
                end
                SB_ACK_W:   state <= SB_WDATA;
                SB_RDATA:   if (byte_done) begin
                    state <= SB_ACK_R;
                end
                SB_ACK_R:   state <= host_nack ? SB_IDLE : SB_RDATA;
            endcase
        end
    end

    // Bit counter and receive shifter work on rising clock edges
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bitcnt <= 4'h0;
            shreg  <= 8'h00;
        end else if (bus_start || byte_done) begin
            bitcnt <= 4'h0;
        end else if (scl_rise && bitcnt != BITS_PER_BYTE
                     && (state == SB_DEVADDR || state == SB_REGADDR
                         || state == SB_WDATA || state == SB_RDATA)) begin
            bitcnt <= bitcnt + 4'h1;
            shreg  <= {shreg[6:0], sda_sync[1]};
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rw_read   <= 1'b0;
            host_nack <= 1'b0;
        end else begin
            if (byte_done && state == SB_DEVADDR) begin
                rw_read <= shreg[0];
            end
            if (scl_rise && state == SB_ACK_R) begin
                host_nack <= sda_sync[1];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ptr <= 8'h00;
        end else if (byte_done && state == SB_REGADDR) begin
            ptr <= shreg;
        end else if (ptr_advance) begin
            ptr <= next_ptr;
        end
    end

    // Transmit shifter: loaded when a read byte starts, shifted on falls
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            txreg <= 8'hFF;
        end else if (scl_fall && state == SB_ACK_DEV && rw_read) begin
            txreg <= read_data;
        end else if (ptr_advance && state == SB_ACK_R) begin
            txreg <= read_data;
        end else if (scl_fall && state == SB_RDATA && !byte_done) begin
            txreg <= {txreg[6:0], 1'b1};
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sda_oe_out <= 1'b0;
        end else begin
            sda_oe_out <= (state == SB_ACK_DEV) | (state == SB_ACK_REG)
                        | (state == SB_ACK_W) | ((state == SB_RDATA) & ~txreg[7]);
        end
    end

    assign sda_out = 1'b0;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            channel9_control <= RESET_CONTROL;
        end else if (write_strobe && ptr == ADDR_CH9_CONTROL) begin
            channel9_control <= shreg;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            channel1_duty <= RESET_DUTY;
        end else if (write_strobe && ptr == ADDR_CH1_DUTY) begin
            channel1_duty <= shreg;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            channel2_duty <= RESET_DUTY;
        end else if (write_strobe && ptr == ADDR_CH2_DUTY) begin
            channel2_duty <= shreg;
        end
    end

    // ------------------------------------------------------------
    // Output channels: index 0 ch1, 1 ch2, 2 ch9
    // ------------------------------------------------------------
    assign ctrl_arr = {channel9_control, ctrl_ch2_in, ctrl_ch1_in};
    assign duty_arr = {duty_ch9_in, channel2_duty, channel1_duty};

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        lcp_chan_pwm u_chan (
            .mclk_in          (mclk_in),
            .reset_n_in       (reset_n_in),
            .ctrl_in          (ctrl_arr[ch]),
            .direct_duty_in   (duty_arr[ch]),
            .engine_duty_in   (engine_duty_in[ch]),
            .engine_active_in (engine_active_in[ch]),
            .fader_levels_in  (fader_levels_in),
            .temperature_in   (temperature_in),
            .pwm_out          (pwm_out[ch])
        );
    end

endmodule : lcp_led_ctrl
`default_nettype wire

/* verification/lcp_led_ctrl_assertions.sv */
`default_nettype none
module lcp_led_ctrl_assertions (
    input wire logic                     mclk_in,
    input wire logic                     reset_n_in,
    input wire logic                     scl_in,
    input wire logic                     sda_in,
    input wire logic                     sda_out,
    input wire logic                     sda_oe_out,
    input wire lcp_pkg::lcp_ctrl_t       ctrl_ch1_in,
    input wire lcp_pkg::lcp_ctrl_t       ctrl_ch2_in,
    input wire lcp_pkg::lcp_duty_t       duty_ch9_in,
    input wire lcp_pkg::lcp_duty_t [2:0] engine_duty_in,
    input wire logic [2:0]               engine_active_in,
    input wire logic [23:0]              fader_levels_in,
    input wire logic signed [7:0]        temperature_in,
    input wire logic [2:0]               pwm_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import lcp_pkg::*;
    // ------------------------------------------------------------
    // Output relations
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);
    // Eight steady cycles cover the duty pipeline before pwm_out is judged
    logic half_on;
    assign half_on = engine_active_in[0] && ctrl_ch1_in == 8'h00 && engine_duty_in[0] == 8'h80;
    property p_full_on;
        (engine_active_in[0] && engine_duty_in[0] == DUTY_FULL && ctrl_ch1_in == 8'h00)[*8]
            |=> pwm_out[0];
    endproperty
    a_full_on: assert property (p_full_on) else $error("full duty not held on");
    property p_zero_off;
        (engine_active_in[1] && engine_duty_in[1] == 8'h00)[*8] |=> !pwm_out[1];
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero duty not off");
    property p_engine_override;
        (engine_active_in[2] && engine_duty_in[2] == 8'h00 && duty_ch9_in == DUTY_FULL)[*8]
            |=> !pwm_out[2];
    endproperty
    a_engine_override: assert property (p_engine_override) else $error("direct duty used");
    property p_ref_temp;
        (engine_active_in[1] && engine_duty_in[1] == DUTY_FULL && ctrl_ch2_in[7:5] == 3'h0
            && temperature_in == 8'sd25)[*8] |=> pwm_out[1];
    endproperty
    a_ref_temp: assert property (p_ref_temp) else $error("slope acts at 25 C");
    property p_fader_zero;
        (engine_active_in[1] && ctrl_ch2_in[7:6] == 2'h1 && fader_levels_in[7:0] == 8'h00)[*8]
            |=> !pwm_out[1];
    endproperty
    a_fader_zero: assert property (p_fader_zero) else $error("fader 1 at zero not off");
    property p_log_small;
        (engine_active_in[0] && ctrl_ch1_in == 8'h20 && engine_duty_in[0] < 8'h10)[*8]
            |=> !pwm_out[0];
    endproperty
    a_log_small: assert property (p_log_small) else $error("log curve not applied");
    property p_period;
        half_on[*8] ##0 $rose(pwm_out[0]) |-> ##128 ($fell(pwm_out[0]) || !half_on);
    endproperty
    a_period: assert property (p_period) else $error("duty 80 not 128 cycles high");
    property p_ack_scl_low;
        $changed(sda_oe_out) |-> !scl_in;
    endproperty
    a_ack_scl_low: assert property (p_ack_scl_low) else $error("data moved with clock high");
endmodule : lcp_led_ctrl_assertions
bind lcp_led_ctrl lcp_led_ctrl_assertions u_lcp_led_ctrl_assertions (
    .mclk_in, .reset_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .ctrl_ch1_in,
    .ctrl_ch2_in, .duty_ch9_in, .engine_duty_in, .engine_active_in, .fader_levels_in,
    .temperature_in, .pwm_out
);
`default_nettype wire

/* verification/lcp_host.sv */
`default_nettype none
module lcp_host (
    input  wire logic mclk_in,
    input  wire logic sda_in,
    output var logic  scl_out,
    output var logic  sda_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import lcp_pkg::*;
    int nak_count = 0;
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // ------------------------------------------------------------
    // Bus phases: 8 mclk each, twice the slowest the device allows
    // ------------------------------------------------------------
    task automatic half();
        repeat (8) @(posedge mclk_in);
    endtask : half
    // Start is edges(1,0,0), stop is edges(0,1,1)
    task automatic edges(input logic a, input logic b, input logic c);
        half();
        sda_out <= a;
        half();
        scl_out <= 1'b1;
        half();
        sda_out <= b;
        half();
        scl_out <= c;
    endtask : edges
    task automatic bit_cyc(input logic x, output logic s);
        half();
        sda_out <= x;
        half();
        scl_out <= 1'b1;
        half();
        s = sda_in;
        scl_out <= 1'b0;
    endtask : bit_cyc
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                        output logic s);
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(tx[i], rx[i]);
        end
        bit_cyc(last, s);
    endtask : xfer
    task automatic send(input logic [7:0] b);
        logic [7:0] rx;
        logic       s;
        xfer(b, 1'b1, rx, s);
        if (s) nak_count++;
    endtask : send
    // Every call names its register itself; a second byte goes wherever the pointer steps to
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
                             input int n);
        edges(1'b1, 1'b0, 1'b0);
        send({DEV_ADDR_DEFAULT, 1'b0});
        send(a);
        send(d0);
        if (n > 1) send(d1);
        edges(1'b0, 1'b1, 1'b1);
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, input int n, output logic [7:0] q0,
                            output logic [7:0] q1);
        logic s;
        q1 = 8'h00;
        edges(1'b1, 1'b0, 1'b0);
        send({DEV_ADDR_DEFAULT, 1'b0});
        send(a);
        edges(1'b1, 1'b0, 1'b0);
        send({DEV_ADDR_DEFAULT, 1'b1});
        xfer(8'hFF, n == 1, q0, s);
        if (n > 1) xfer(8'hFF, 1'b1, q1, s);
        edges(1'b0, 1'b1, 1'b1);
    endtask : read_reg
endmodule : lcp_host
`default_nettype wire

/* verification/test_lcp_led_ctrl.sv */
`default_nettype none
module test_lcp_led_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import lcp_pkg::*;
    logic              mclk_in, reset_n_in, scl, host_sda, sda_drv, sda_oe;
    wire               sda_wire;
    lcp_ctrl_t         ctrl_ch1, ctrl_ch2;
    lcp_duty_t         duty_ch9;
    lcp_duty_t [2:0]   engine_duty;
    logic [2:0]        engine_active, pwm;
    logic [23:0]       fader_levels;
    logic signed [7:0] temperature;
    logic [7:0]        r_ch1, r_ch2, ctrl9, q0, q1, c9;
    logic [31:0]       seed;
    int                fails, cmp_count;
    // Pull-up: released line reads high
    assign sda_wire = host_sda & (sda_oe ? sda_drv : 1'b1);
    lcp_host u_lcp_host (.mclk_in(mclk_in), .sda_in(sda_wire), .scl_out(scl), .sda_out(host_sda));
    lcp_led_ctrl u_lcp_led_ctrl (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_drv), .sda_oe_out(sda_oe), .ctrl_ch1_in(ctrl_ch1), .ctrl_ch2_in(ctrl_ch2),
        .duty_ch9_in(duty_ch9), .engine_duty_in(engine_duty), .engine_active_in(engine_active),
        .fader_levels_in(fader_levels), .temperature_in(temperature), .pwm_out(pwm)
    );
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic int eff(int b, logic [7:0] c, logic [23:0] f, int t);
        int d;
        int sl;
        d = b;
        if (c[7:6] != 2'h0) d = (d * int'((f >> (8 * (int'(c[7:6]) - 1))) & 24'hFF) + d) >> 8;
        if (c[5]) d = (d * d + d) >> 8;
        sl = c[4] ? -int'(c[3:0]) : int'(c[3:0]);
        d = d + ((d * sl * (t - 25)) >>> 10);
        if (d < 0) d = 0;
        if (d > 255) d = 255;
        return d;
    endfunction : eff
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask : check
    // Over any 255-cycle window the high count equals the effective duty
    task automatic check_pwm();
        int         cnt[3];
        logic [7:0] dir[3];
        logic [7:0] cs[3];
        cnt = '{0, 0, 0};
        repeat (300) @(posedge mclk_in);
        dir = '{r_ch1, r_ch2, duty_ch9};
        cs = '{ctrl_ch1, ctrl_ch2, ctrl9};
        repeat (255) begin
            @(posedge mclk_in);
            for (int k = 0; k < 3; k++) cnt[k] += (pwm[k] === 1'b1) ? 1 : 0;
        end
        for (int k = 0; k < 3; k++) begin
            check("pwm high count", 8'(eff(engine_active[k] ? engine_duty[k] : dir[k], cs[k],
                  fader_levels, temperature)), 8'(cnt[k]));
        end
    endtask : check_pwm
    task automatic close_out();
        if (fails == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {reset_n_in, ctrl_ch1, ctrl_ch2, duty_ch9, engine_duty, engine_active} = '0;
        {fader_levels, temperature, r_ch1, r_ch2, ctrl9, fails, cmp_count} = '0;
        seed = 32'd62;
        repeat (3) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        u_lcp_host.read_reg(ADDR_CH9_CONTROL, 1, q0, q1);
        check("control reset", RESET_CONTROL, q0);
        u_lcp_host.read_reg(ADDR_CH1_DUTY, 2, q0, q1);
        check("duty1 reset", RESET_DUTY, q0);
        check("duty1 reread", RESET_DUTY, q1);
        check_pwm();
        u_lcp_host.write_reg(ADDR_CH1_DUTY, 8'h01, 8'h00, 1);
        u_lcp_host.write_reg(ADDR_CH2_DUTY, DUTY_FULL, 8'h00, 1);
        {r_ch1, r_ch2} = {8'h01, DUTY_FULL};
        check_pwm();
        u_lcp_host.write_reg(ADDR_CH1_DUTY, 8'h11, 8'h22, 2);
        r_ch1 = 8'h22;
        u_lcp_host.read_reg(ADDR_CH2_DUTY, 2, q0, q1);
        check("duty2 first", DUTY_FULL, q0);
        check("duty2 again", DUTY_FULL, q1);
        u_lcp_host.read_reg(ADDR_CH1_DUTY, 1, q0, q1);
        check("duty1 last write", 8'h22, q0);
        u_lcp_host.write_reg(ADDR_CH9_CONTROL, 8'h41, 8'h99, 2);
        ctrl9 = 8'h41;
        u_lcp_host.read_reg(ADDR_CH9_CONTROL, 1, q0, q1);
        check("control after step", 8'h41, q0);
        u_lcp_host.write_reg(8'h30, 8'hA5, 8'h00, 1);
        u_lcp_host.read_reg(8'h30, 1, q0, q1);
        check("unmapped read", READ_UNMAPPED, q0);
        u_lcp_host.edges(1'b1, 1'b0, 1'b0);
        u_lcp_host.send({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0});
        u_lcp_host.edges(1'b0, 1'b1, 1'b1);
        engine_active <= 3'b111;
        engine_duty <= {8'h00, DUTY_FULL, DUTY_FULL};
        {ctrl_ch2, duty_ch9, temperature} <= {8'h1F, DUTY_FULL, 8'sd25};
        check_pwm();
        engine_duty <= {8'h00, 8'hC3, 8'h80};
        ctrl_ch2 <= 8'h40;
        check_pwm();
        engine_duty <= {8'h40, 8'h00, 8'h0F};
        {engine_active, ctrl_ch1} <= {3'b011, 8'h20};
        check_pwm();
        for (int i = 0; i < 8; i++) begin
            c9 = {i[1:0], i[2], 5'(rnd())};
            if (i < 3) c9[4:0] = (i == 0) ? 5'h00 : (i == 1) ? 5'h0F : 5'h1F;
            if (c9[4:0] == 5'h10) c9[4:0] = 5'h11;
            ctrl9 = c9;
            // Duties kept at or below half so thermal gain has headroom
            r_ch1 = 8'(rnd()) & 8'h7F;
            r_ch2 = 8'(rnd()) & 8'h7F;
            u_lcp_host.write_reg(ADDR_CH9_CONTROL, c9, 8'h00, 1);
            u_lcp_host.write_reg(ADDR_CH1_DUTY, r_ch1, 8'h00, 1);
            u_lcp_host.write_reg(ADDR_CH2_DUTY, r_ch2, 8'h00, 1);
            {ctrl_ch1, ctrl_ch2, duty_ch9} <= {16'(rnd()), 8'(rnd()) & 8'h7F};
            {engine_duty, engine_active} <= {24'(rnd()) & 24'h7F7F7F, 3'(rnd())};
            fader_levels <= 24'(rnd());
            temperature <= 8'(int'(rnd() % 131) - 40);
            check_pwm();
        end
        check("refused bytes", 8'h01, 8'(u_lcp_host.nak_count));
        close_out();
    end
endmodule : test_lcp_led_ctrl
`default_nettype wire
